// ===== rtl/cth_map.vh
// Register map, field positions and encodings of the cascade header handler.
`ifndef CTH_MAP_VH
`define CTH_MAP_VH
// ---------------------------------------------------------------------------
// Register offsets (byte addresses, one 32-bit word each)
// ---------------------------------------------------------------------------
`define CTH_REG_CTRL      8'h00
`define CTH_REG_ETYPE     8'h04
`define CTH_REG_TS_ETYPE  8'h08
`define CTH_REG_STATUS    8'h0c
`define CTH_REG_CHIP      8'h10
`define CTH_REG_TIME_LO   8'h14
`define CTH_REG_TIME_HI   8'h18
`define CTH_REG_RX_CNT    8'h1c
// ---------------------------------------------------------------------------
// Control fields
// ---------------------------------------------------------------------------
`define CTH_CTRL_CASCADE  0
`define CTH_CTRL_TAG_ALL  1
`define CTH_CTRL_TS_EN    2
`define CTH_CTRL_CLR      3
// ---------------------------------------------------------------------------
// Reset values and sizes
// ---------------------------------------------------------------------------
`define CTH_ETYPE_RST     16'h0000
`define CTH_TS_ETYPE_RST  16'h0000
`define CTH_CHIP_RST      2'h0
`define CTH_HDR_BYTES     4'h8
`define CTH_SA_END        4'hb
`define CTH_TS_W          48
// ---------------------------------------------------------------------------
// Forwarding operations and exception codes
// ---------------------------------------------------------------------------
`define CTH_FOP_UC        2'h0
`define CTH_FOP_MC        2'h1
`define CTH_FOP_EXC       2'h2
`define CTH_EXC_LEARN     4'h1
`define CTH_EXC_MOVE      4'h2
`define CTH_EXC_MIRROR    4'h3
`define CTH_EXC_TRAP      4'h4
`define CTH_EXC_CLEARN    4'h5
`define CTH_EXC_CMOVE     4'h6
`endif

// ===== rtl/cth_handler.v
// Cascade header insert, parse and strip engine for the management port.
`timescale 1ns/100ps
`include "cth_map.vh"

module cth_handler (
  input wire CORE_CLK_I,
  input wire RST_B_I,
  input wire CE_I,
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  output reg [31:0] RDATA_O,
  // Egress side: frame toward host or cascade partner.
  input wire EG_VALID_I,
  input wire [7:0] EG_DATA_I,
  input wire EG_SOP_I,
  input wire EG_EOP_I,
  output wire EG_READY_O,
  input wire EG_PORT_EDIT_I,
  input wire EG_LIF_EDIT_I,
  input wire EG_FLOOD_I,
  input wire EG_MISS_I,
  input wire [1:0] EG_FORWARDING_OPERATION_I,
  input wire [11:0] EG_TARGET_I,
  input wire [3:0] EG_PHYS_PORT_I,
  input wire [3:0] EG_SPG_I,
  input wire [11:0] EG_SLIF_I,
  input wire [11:0] EG_INST_I,
  input wire EG_KIND_I,
  input wire [1:0] EG_CHIP_I,
  input wire [47:0] EG_ARRIVAL_TS_I,
  output reg TX_VALID_O,
  output reg [7:0] TX_DATA_O,
  output reg TX_SOP_O,
  output reg TX_EOP_O,
  input wire TX_READY_I,
  // Ingress side: frame from host or cascade partner.
  input wire RX_VALID_I,
  input wire [7:0] RX_DATA_I,
  input wire RX_SOP_I,
  input wire RX_EOP_I,
  output reg IN_VALID_O,
  output reg [7:0] IN_DATA_O,
  output reg IN_SOP_O,
  output reg IN_EOP_O,
  output reg IN_TAGGED_O,
  output reg [1:0] IN_FORWARDING_OPERATION_O,
  output reg [11:0] IN_TARGET_O,
  output reg [3:0] IN_PHYS_PORT_O,
  output reg [3:0] IN_SPG_O,
  output reg [11:0] IN_SLIF_O,
  output reg [11:0] IN_INST_O,
  output reg IN_KIND_O,
  output reg [1:0] IN_CHIP_O,
  output reg IN_LEARN_O,
  output reg IN_RAW_PORT_O,
  output reg IN_FLOOD_O,
  output reg [15:0] IN_SRC_KEY_O,
  output reg [3:0] IN_MIRROR_GRP_O,
  output reg IN_TRAP_O,
  output reg ADDR_WR_O
);

// ---------------------------------------------------------------------------
// Helper functions
// ---------------------------------------------------------------------------
// Pick byte n (0 = first on the wire) from a 64-bit header word.
function [7:0] hdr_byte;
  input [63:0] hdr;
  input [3:0] n;
  begin
    hdr_byte = hdr[8'd63 - {n, 3'h0} -: 8];
  end
endfunction

// Convert a local learn or move exception into its cascaded form.
function [3:0] cascade_exc;
  input [3:0] exc;
  begin
    case (exc)
      `CTH_EXC_LEARN: cascade_exc = `CTH_EXC_CLEARN;
      `CTH_EXC_MOVE: cascade_exc = `CTH_EXC_CMOVE;
      default: cascade_exc = exc;
    endcase
  end
endfunction

// ---------------------------------------------------------------------------
// Register file
// ---------------------------------------------------------------------------
reg [3:0] ctrl_r;
reg [15:0] etype_r;
reg [15:0] ts_etype_r;
reg [1:0] chip_r;
reg drop_flag_r;
reg [15:0] rx_cnt_r;
reg [47:0] now_r;
wire clr_req = CE_I & WR_I & (ADDR_I == `CTH_REG_CTRL) &
               WDATA_I[`CTH_CTRL_CLR];
wire drop_evt;
wire rx_done_evt;

// Software writes steer the engine; the free running counter is only read back, arrivals carry their own stamp.
always @(posedge CORE_CLK_I or negedge RST_B_I) begin
  if (!RST_B_I) begin
    ctrl_r <= 4'h0;
    etype_r <= `CTH_ETYPE_RST;
    ts_etype_r <= `CTH_TS_ETYPE_RST;
    chip_r <= `CTH_CHIP_RST;
    now_r <= 48'h0;
  end else if (CE_I) begin
    now_r <= now_r + 48'h1;
    if (WR_I) begin
      case (ADDR_I)
        `CTH_REG_CTRL: ctrl_r <= {1'b0, WDATA_I[2:0]};
        `CTH_REG_ETYPE: etype_r <= WDATA_I[15:0];
        `CTH_REG_TS_ETYPE: ts_etype_r <= WDATA_I[15:0];
        `CTH_REG_CHIP: chip_r <= WDATA_I[1:0];
        default: ;
      endcase
    end
  end
end

// Drop flag and ingress frame count; a new event wins over the clear.
always @(posedge CORE_CLK_I or negedge RST_B_I) begin
  if (!RST_B_I) begin
    drop_flag_r <= 1'b0;
    rx_cnt_r <= 16'h0;
  end else if (CE_I) begin
    drop_flag_r <= drop_evt | (drop_flag_r & ~clr_req);
    if (rx_done_evt)
      rx_cnt_r <= rx_cnt_r + 16'h1;
    else if (clr_req)
      rx_cnt_r <= 16'h0;
  end
end

// Read data stands in the cycle after the read strobe.
always @(posedge CORE_CLK_I or negedge RST_B_I) begin
  if (!RST_B_I) begin
    RDATA_O <= 32'h0;
  end else if (CE_I) begin
    if (RD_I) begin
      case (ADDR_I)
        `CTH_REG_CTRL: RDATA_O <= {28'h0, ctrl_r};
        `CTH_REG_ETYPE: RDATA_O <= {16'h0, etype_r};
        `CTH_REG_TS_ETYPE: RDATA_O <= {16'h0, ts_etype_r};
        `CTH_REG_STATUS: RDATA_O <= {31'h0, drop_flag_r};
        `CTH_REG_CHIP: RDATA_O <= {30'h0, chip_r};
        `CTH_REG_TIME_LO: RDATA_O <= now_r[31:0];
        `CTH_REG_TIME_HI: RDATA_O <= {16'h0, now_r[47:32]};
        `CTH_REG_RX_CNT: RDATA_O <= {16'h0, rx_cnt_r};
        default: RDATA_O <= 32'h0;
      endcase
    end else begin
      RDATA_O <= 32'h0;
    end
  end
end

// ---------------------------------------------------------------------------
// Egress: header insertion
// ---------------------------------------------------------------------------
localparam EG_COPY = 2'h0;
localparam EG_HDR = 2'h1;
localparam EG_TS = 2'h2;
localparam EG_BODY = 2'h3;

reg [1:0] eg_st_r;
reg [3:0] eg_cnt_r;
reg [3:0] eg_hcnt_r;
reg [63:0] eg_hdr_r;
reg [63:0] eg_ts_r;
reg eg_ins_r;
reg eg_tsen_r;
reg [7:0] eg_hold_r;
reg eg_hold_v_r;
reg [1:0] fop;
reg [11:0] tgt;

// Header fields toward the host, built from the frame's forwarding result.
always @* begin
  fop = EG_FORWARDING_OPERATION_I;
  tgt = EG_TARGET_I;
  if (EG_MISS_I) begin
    fop = `CTH_FOP_UC;
    tgt = 12'h0;
  end else if (EG_FLOOD_I) begin
    fop = `CTH_FOP_MC;
    tgt = 12'h0;
  end else if (EG_FORWARDING_OPERATION_I == `CTH_FOP_EXC) begin
    tgt = {EG_TARGET_I[11:4], cascade_exc(EG_TARGET_I[3:0])};
  end
end

// The output stage is free when empty or when the sink takes its byte.
wire tx_free = ~TX_VALID_O | TX_READY_I;
// Ready is low while the header or stamp is emitted, so the source waits then.
assign EG_READY_O = tx_free & ~eg_hold_v_r &
                    ((eg_st_r == EG_COPY) | (eg_st_r == EG_BODY));
wire eg_take = EG_VALID_I & EG_READY_O;
wire eg_ins_now = EG_PORT_EDIT_I | EG_LIF_EDIT_I | ctrl_r[`CTH_CTRL_CASCADE];

always @(posedge CORE_CLK_I or negedge RST_B_I) begin
  if (!RST_B_I) begin
    eg_st_r <= EG_COPY;
    eg_cnt_r <= 4'h0;
    eg_hcnt_r <= 4'h0;
    eg_hdr_r <= 64'h0;
    eg_ts_r <= 64'h0;
    eg_ins_r <= 1'b0;
    eg_tsen_r <= 1'b0;
    eg_hold_r <= 8'h0;
    eg_hold_v_r <= 1'b0;
    TX_VALID_O <= 1'b0;
    TX_DATA_O <= 8'h0;
    TX_SOP_O <= 1'b0;
    TX_EOP_O <= 1'b0;
  end else if (CE_I) begin
    if (TX_READY_I)
      TX_VALID_O <= 1'b0;
    case (eg_st_r)
      EG_COPY: begin
        if (eg_take) begin
          TX_VALID_O <= 1'b1;
          TX_DATA_O <= EG_DATA_I;
          TX_SOP_O <= EG_SOP_I;
          TX_EOP_O <= EG_EOP_I;
          if (EG_SOP_I) begin
            // Directive from port edit table or egress lif; cascade always.
            eg_ins_r <= eg_ins_now | ctrl_r[`CTH_CTRL_TAG_ALL];
            eg_tsen_r <= ctrl_r[`CTH_CTRL_TS_EN];
            eg_ts_r <= {ts_etype_r, EG_ARRIVAL_TS_I};
            // Source context, chip index and trap port filled in.
            eg_hdr_r <= {etype_r, fop, tgt,
                         (fop == `CTH_FOP_EXC && tgt[3:0] == `CTH_EXC_TRAP) ?
                         EG_PHYS_PORT_I : EG_SPG_I,
                         EG_KIND_I, EG_CHIP_I, EG_SLIF_I,
                         3'h0, EG_INST_I};
            eg_cnt_r <= 4'h1;
          end else if (eg_cnt_r != 4'h0) begin
            eg_cnt_r <= eg_cnt_r + 4'h1;
          end
          if (eg_cnt_r == `CTH_SA_END && (eg_ins_r | eg_ins_now)) begin
            // Last source MAC byte sent: header goes next.
            eg_st_r <= EG_HDR;
            eg_hcnt_r <= 4'h0;
            eg_cnt_r <= 4'h0;
          end
        end
      end
      EG_HDR: begin
        if (tx_free) begin
          TX_VALID_O <= 1'b1;
          TX_DATA_O <= hdr_byte(eg_hdr_r, eg_hcnt_r);
          TX_SOP_O <= 1'b0;
          TX_EOP_O <= 1'b0;
          eg_hcnt_r <= eg_hcnt_r + 4'h1;
          if (eg_hcnt_r == `CTH_HDR_BYTES - 4'h1) begin
            eg_hcnt_r <= 4'h0;
            eg_st_r <= eg_tsen_r ? EG_TS : EG_BODY;
          end
        end
      end
      EG_TS: begin
        if (tx_free) begin
          TX_VALID_O <= 1'b1;
          TX_DATA_O <= hdr_byte(eg_ts_r, eg_hcnt_r);
          TX_SOP_O <= 1'b0;
          TX_EOP_O <= 1'b0;
          eg_hcnt_r <= eg_hcnt_r + 4'h1;
          if (eg_hcnt_r == `CTH_HDR_BYTES - 4'h1)
            eg_st_r <= EG_BODY;
        end
      end
      EG_BODY: begin
        if (eg_take) begin
          TX_VALID_O <= 1'b1;
          TX_DATA_O <= EG_DATA_I;
          TX_SOP_O <= 1'b0;
          TX_EOP_O <= EG_EOP_I;
          if (EG_EOP_I) begin
            eg_st_r <= EG_COPY;
            eg_ins_r <= 1'b0;
          end
        end
      end
      default: eg_st_r <= EG_COPY;
    endcase
  end
end

// ---------------------------------------------------------------------------
// Ingress: header parse and strip
// ---------------------------------------------------------------------------
// Bytes 12..13 are compared with the EtherType; until then the frame's
// first twelve bytes wait in a small array so the header can be cut out.
reg [7:0] rx_mem [0:13];
reg [3:0] rx_cnt_b_r;
reg [3:0] rx_hcnt_r;
reg [63:0] rx_hdr_r;
reg rx_in_r;
reg rx_tag_r;
reg rx_drop_r;
reg [3:0] rx_rep_r;
reg rx_rep_v_r;
reg rx_first_r;
wire rx_etype_hit = ({rx_mem[12], RX_DATA_I} == etype_r);
wire [63:0] rx_hdr_full = {rx_hdr_r[55:0], RX_DATA_I};

assign drop_evt = RX_VALID_I & (rx_cnt_b_r == 4'hd) & rx_in_r &
                  ~rx_etype_hit & ctrl_r[`CTH_CTRL_CASCADE];
assign rx_done_evt = IN_VALID_O & IN_EOP_O;

always @(posedge CORE_CLK_I or negedge RST_B_I) begin
  if (!RST_B_I) begin
    rx_cnt_b_r <= 4'h0;
    rx_hcnt_r <= 4'h0;
    rx_hdr_r <= 64'h0;
    rx_in_r <= 1'b0;
    rx_tag_r <= 1'b0;
    rx_drop_r <= 1'b0;
    rx_rep_r <= 4'h0;
    rx_rep_v_r <= 1'b0;
    rx_first_r <= 1'b0;
    IN_VALID_O <= 1'b0;
    IN_DATA_O <= 8'h0;
    IN_SOP_O <= 1'b0;
    IN_EOP_O <= 1'b0;
    IN_TAGGED_O <= 1'b0;
    IN_FORWARDING_OPERATION_O <= 2'h0;
    IN_TARGET_O <= 12'h0;
    IN_PHYS_PORT_O <= 4'h0;
    IN_SPG_O <= 4'h0;
    IN_SLIF_O <= 12'h0;
    IN_INST_O <= 12'h0;
    IN_KIND_O <= 1'b0;
    IN_CHIP_O <= 2'h0;
    IN_LEARN_O <= 1'b0;
    IN_RAW_PORT_O <= 1'b0;
    IN_FLOOD_O <= 1'b0;
    IN_SRC_KEY_O <= 16'h0;
    IN_MIRROR_GRP_O <= 4'h0;
    IN_TRAP_O <= 1'b0;
    ADDR_WR_O <= 1'b0;
  end else if (CE_I) begin
    IN_VALID_O <= 1'b0;
    IN_SOP_O <= 1'b0;
    IN_EOP_O <= 1'b0;
    ADDR_WR_O <= 1'b0;
    // Replay the held addresses one byte per cycle after the decision.
    if (rx_rep_v_r) begin
      IN_VALID_O <= 1'b1;
      IN_DATA_O <= rx_mem[rx_rep_r];
      IN_SOP_O <= rx_first_r;
      rx_first_r <= 1'b0;
      rx_rep_r <= rx_rep_r + 4'h1;
      if (rx_rep_r == (rx_tag_r ? `CTH_SA_END : 4'hd))
        rx_rep_v_r <= 1'b0;
    end
    if (RX_VALID_I) begin
      if (RX_SOP_I) begin
        rx_in_r <= 1'b1;
        rx_tag_r <= 1'b0;
        rx_drop_r <= 1'b0;
        rx_mem[0] <= RX_DATA_I;
        rx_cnt_b_r <= 4'h1;
      end else if (rx_in_r && rx_cnt_b_r < 4'hd) begin
        rx_mem[rx_cnt_b_r] <= RX_DATA_I;
        rx_cnt_b_r <= rx_cnt_b_r + 4'h1;
      end else if (rx_in_r && rx_cnt_b_r == 4'hd) begin
        rx_cnt_b_r <= 4'he;
        if (rx_etype_hit) begin
          rx_tag_r <= 1'b1;
          rx_hcnt_r <= 4'h2;
          rx_hdr_r <= {48'h0, etype_r};
        end else if (ctrl_r[`CTH_CTRL_CASCADE]) begin
          rx_drop_r <= 1'b1;
          rx_in_r <= 1'b0;
        end else begin
          // Untagged: normal lookup and learning; EtherType bytes kept.
          rx_mem[13] <= RX_DATA_I;
          rx_rep_v_r <= 1'b1;
          rx_rep_r <= 4'h0;
          rx_first_r <= 1'b1;
          IN_TAGGED_O <= 1'b0;
          IN_LEARN_O <= 1'b1;
          IN_RAW_PORT_O <= 1'b0;
          IN_FLOOD_O <= 1'b0;
          IN_TRAP_O <= 1'b0;
        end
      end else if (rx_in_r && rx_tag_r && rx_hcnt_r != 4'h0) begin
        rx_hdr_r <= rx_hdr_full;
        rx_hcnt_r <= rx_hcnt_r + 4'h1;
        if (rx_hcnt_r == `CTH_HDR_BYTES - 4'h1) begin
          rx_hcnt_r <= 4'h0;
          rx_rep_v_r <= 1'b1;
          rx_rep_r <= 4'h0;
          rx_first_r <= 1'b1;
          // Source context rebuilt from the header.
          IN_TAGGED_O <= 1'b1;
          IN_FORWARDING_OPERATION_O <= rx_hdr_full[47:46];
          IN_TARGET_O <= rx_hdr_full[45:34];
          IN_SPG_O <= rx_hdr_full[33:30];
          IN_PHYS_PORT_O <= rx_hdr_full[33:30];
          IN_KIND_O <= rx_hdr_full[29];
          IN_CHIP_O <= rx_hdr_full[28:27];
          IN_SLIF_O <= rx_hdr_full[26:15];
          IN_INST_O <= rx_hdr_full[11:0];
          IN_SRC_KEY_O <= {rx_hdr_full[29], rx_hdr_full[33:30],
                           rx_hdr_full[10:0]};
          IN_FLOOD_O <= (rx_hdr_full[47:46] == `CTH_FOP_MC) &&
                        (rx_hdr_full[45:34] == 12'h0);
          IN_RAW_PORT_O <= (rx_hdr_full[47:46] == `CTH_FOP_UC) &&
                           (rx_hdr_full[45:34] == 12'h0);
          IN_LEARN_O <= (rx_hdr_full[47:46] == `CTH_FOP_UC) &&
                        (rx_hdr_full[45:34] != 12'h0);
          IN_MIRROR_GRP_O <= rx_hdr_full[41:38];
          IN_TRAP_O <= (rx_hdr_full[47:46] == `CTH_FOP_EXC) &&
                       (rx_hdr_full[37:34] == `CTH_EXC_TRAP);
          ADDR_WR_O <= (rx_hdr_full[47:46] == `CTH_FOP_EXC) &&
                       ((rx_hdr_full[37:34] == `CTH_EXC_CLEARN) ||
                        (rx_hdr_full[37:34] == `CTH_EXC_CMOVE));
        end
      end else if (rx_in_r) begin
        // Body bytes follow the replayed addresses after a short gap.
        IN_VALID_O <= 1'b1;
        IN_DATA_O <= RX_DATA_I;
        IN_EOP_O <= RX_EOP_I;
        if (RX_EOP_I)
          rx_in_r <= 1'b0;
      end
    end
  end
end

endmodule

// ===== verif/cth_handler_monitor.sv
// Concurrent checks on the cascade header handler ports.
`timescale 1ns/100ps
`include "cth_map.vh"
module cth_handler_monitor (
  input wire CORE_CLK_I,
  input wire RST_B_I,
  input wire CE_I,
  input wire [7:0] ADDR_I,
  input wire [31:0] WDATA_I,
  input wire WR_I,
  input wire RD_I,
  input wire [31:0] RDATA_O,
  input wire EG_VALID_I,
  input wire EG_SOP_I,
  input wire EG_EOP_I,
  input wire EG_READY_O,
  input wire EG_PORT_EDIT_I,
  input wire EG_LIF_EDIT_I,
  input wire TX_VALID_O,
  input wire [7:0] TX_DATA_O,
  input wire TX_SOP_O,
  input wire TX_EOP_O,
  input wire TX_READY_I,
  input wire IN_VALID_O,
  input wire IN_SOP_O
);
  reg [15:0] etype_r;
  reg [2:0] ctrl_r;
  reg ins_r;
  reg ts_r;
  reg [7:0] eg_cnt_r;
  reg [7:0] eg_len_r;
  reg [7:0] tx_idx_r;
  wire eg_acc = EG_VALID_I && EG_READY_O;
  wire tx_acc = TX_VALID_O && TX_READY_I;
  wire [7:0] eg_nxt = EG_SOP_I ? 8'h01 : eg_cnt_r + 8'h01;
  wire [7:0] tx_want = eg_len_r + (ins_r ? 8'h08 : 8'h00) +
    ((ins_r && ts_r) ? 8'h08 : 8'h00);
  // Shadow settings and lengths; the output length is only known once
  // the last input byte of the frame has been taken.
  always @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      etype_r <= `CTH_ETYPE_RST;
      ctrl_r <= 3'h0;
      ins_r <= 1'h0;
      ts_r <= 1'h0;
      eg_cnt_r <= 8'h00;
      eg_len_r <= 8'h00;
      tx_idx_r <= 8'h00;
    end else if (CE_I) begin
      if (WR_I && ADDR_I == `CTH_REG_ETYPE) etype_r <= WDATA_I[15:0];
      if (WR_I && ADDR_I == `CTH_REG_CTRL) ctrl_r <= WDATA_I[2:0];
      if (eg_acc && EG_SOP_I) begin
        ins_r <= EG_PORT_EDIT_I | EG_LIF_EDIT_I | ctrl_r[0] | ctrl_r[1];
        ts_r <= ctrl_r[2];
      end
      if (eg_acc) eg_cnt_r <= eg_nxt;
      if (eg_acc && EG_EOP_I) eg_len_r <= eg_nxt;
      if (tx_acc) tx_idx_r <= TX_EOP_O ? 8'h00 : tx_idx_r + 8'h01;
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);
  chk_rdata_quiet: assert property ($past(CE_I) && !$past(RD_I) |->
    RDATA_O == 32'h0) else $error("read data not zero when idle");
  chk_unmapped_zero: assert property (RD_I && CE_I && ADDR_I > 8'h1c |=>
    RDATA_O == 32'h0) else $error("unmapped read not zero");
  chk_etype_echo: assert property (
    RD_I && CE_I && ADDR_I == `CTH_REG_ETYPE |=>
    RDATA_O[15:0] == $past(etype_r)) else $error("header type mismatch");
  chk_tx_stands: assert property (TX_VALID_O && !TX_READY_I |=>
    TX_VALID_O && $stable(TX_DATA_O) && $stable(TX_EOP_O))
    else $error("output byte dropped while stalled");
  chk_ready_busy: assert property (TX_VALID_O && !TX_READY_I |->
    !EG_READY_O) else $error("input taken while output stalled");
  chk_tx_length: assert property (
    tx_acc && TX_EOP_O |-> tx_idx_r + 8'h01 == tx_want)
    else $error("output frame length wrong");
  chk_hdr_etype: assert property (
    tx_acc && ins_r && tx_idx_r == 8'h0c |-> TX_DATA_O == etype_r[15:8])
    else $error("inserted header type byte wrong");
  chk_tx_sop_first: assert property (tx_acc && TX_SOP_O |->
    tx_idx_r == 8'h00) else $error("start marker not on first byte");
  chk_in_sop_pulse: assert property (IN_SOP_O |-> IN_VALID_O ##1 !IN_SOP_O)
    else $error("ingress start marker malformed");
  cov_tagged_out: cover property (tx_acc && TX_EOP_O && ins_r);
  cov_stamp_out: cover property (tx_acc && TX_EOP_O && ts_r);
  cov_stall: cover property (TX_VALID_O && !TX_READY_I);
endmodule
bind cth_handler cth_handler_monitor i_mon (.CORE_CLK_I(CORE_CLK_I),
  .RST_B_I(RST_B_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I),
  .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O), .EG_VALID_I(EG_VALID_I),
  .EG_SOP_I(EG_SOP_I), .EG_EOP_I(EG_EOP_I), .EG_READY_O(EG_READY_O),
  .EG_PORT_EDIT_I(EG_PORT_EDIT_I), .EG_LIF_EDIT_I(EG_LIF_EDIT_I),
  .TX_VALID_O(TX_VALID_O), .TX_DATA_O(TX_DATA_O), .TX_SOP_O(TX_SOP_O),
  .TX_EOP_O(TX_EOP_O), .TX_READY_I(TX_READY_I), .IN_VALID_O(IN_VALID_O),
  .IN_SOP_O(IN_SOP_O));

// ===== verif/cth_host_model.sv
// Host processor model that sinks the framed stream.
`timescale 1ns/100ps
module cth_host_model (
  input wire clk_i,
  input wire rst_b_i,
  input wire clr_i,
  input wire stall_i,
  input wire valid_i,
  input wire [7:0] data_i,
  input wire eop_i,
  output reg ready_o
);
  integer seed = 77;
  integer n_got = 0;
  reg done_r = 1'h0;
  reg [7:0] got [0:63];
  // Tagged and untagged frames are taken alike; a slow host drops ready
  // at random so back-pressure reaches the header insertion.
  always @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ready_o <= 1'h0;
    end else begin
      ready_o <= stall_i ? ($random(seed) % 2 == 0) : 1'h1;
      if (clr_i) begin
        n_got <= 0;
        done_r <= 1'h0;
      end else if (valid_i && ready_o && !done_r) begin
        got[n_got] <= data_i;
        n_got <= n_got + 1;
        done_r <= eop_i;
      end
    end
  end
endmodule

// ===== verif/tb.sv
// Self-checking bench for the cascade header handler.
`timescale 1ns/100ps
`include "cth_map.vh"
module tb;
  reg clk = 1'h0, rst_b = 1'h0, wr = 1'h0, rd = 1'h0, clr = 1'h0, ce = 1'h1;
  reg ev = 1'h0, es = 1'h0, ee = 1'h0, pe = 1'h0, le = 1'h0, fl = 1'h0;
  reg ms = 1'h0, knd = 1'h0, rv = 1'h0, rs = 1'h0, re = 1'h0, stall = 1'h0;
  reg [7:0] addr = 8'h00, ed = 8'h00, rx_d = 8'h00, pb = 8'h00, eb;
  reg [31:0] wdata = 32'h0, rnd, rdv;
  reg [1:0] fop = 2'h0, chip = 2'h0;
  reg [3:0] pp = 4'h0, source_port_group = 4'h0;
  reg [11:0] tgt = 12'h0, slif = 12'h0, inst = 12'h0;
  reg [15:0] et, tse;
  reg [47:0] ts = 48'h0;
  reg [63:0] hv, tv;
  wire [31:0] rdata;
  wire [7:0] txd;
  wire [11:0] i_tgt, i_slif, i_inst;
  wire [3:0] i_pp, i_spg, i_mg;
  wire [1:0] i_fop, i_chip;
  wire erdy, txv, txs, txe, txr, iv, itag, ikind, ilrn, iraw, ifl, itrap;
  integer seed = 5130;
  integer n_errors = 0;
  integer samples_checked = 0;
  integer in_cnt = 0;
  integer i, k, j, nh;
  always #5 clk = ~clk;
  cth_handler i_dut (.CORE_CLK_I(clk), .RST_B_I(rst_b), .CE_I(ce),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata),
    .EG_VALID_I(ev), .EG_DATA_I(ed), .EG_SOP_I(es), .EG_EOP_I(ee),
    .EG_READY_O(erdy), .EG_PORT_EDIT_I(pe), .EG_LIF_EDIT_I(le),
    .EG_FLOOD_I(fl), .EG_MISS_I(ms), .EG_FORWARDING_OPERATION_I(fop), .EG_TARGET_I(tgt),
    .EG_PHYS_PORT_I(pp), .EG_SPG_I(source_port_group), .EG_SLIF_I(slif),
    .EG_INST_I(inst), .EG_KIND_I(knd), .EG_CHIP_I(chip),
    .EG_ARRIVAL_TS_I(ts), .TX_VALID_O(txv), .TX_DATA_O(txd),
    .TX_SOP_O(txs), .TX_EOP_O(txe), .TX_READY_I(txr), .RX_VALID_I(rv),
    .RX_DATA_I(rx_d), .RX_SOP_I(rs), .RX_EOP_I(re), .IN_VALID_O(iv),
    .IN_DATA_O(), .IN_SOP_O(), .IN_EOP_O(), .IN_TAGGED_O(itag),
    .IN_FORWARDING_OPERATION_O(i_fop), .IN_TARGET_O(i_tgt), .IN_PHYS_PORT_O(i_pp),
    .IN_SPG_O(i_spg), .IN_SLIF_O(i_slif), .IN_INST_O(i_inst),
    .IN_KIND_O(ikind), .IN_CHIP_O(i_chip), .IN_LEARN_O(ilrn),
    .IN_RAW_PORT_O(iraw), .IN_FLOOD_O(ifl), .IN_SRC_KEY_O(),
    .IN_MIRROR_GRP_O(i_mg), .IN_TRAP_O(itrap), .ADDR_WR_O());
  cth_host_model i_host (.clk_i(clk), .rst_b_i(rst_b), .clr_i(clr),
    .stall_i(stall), .valid_i(txv), .data_i(txd), .eop_i(txe),
    .ready_o(txr));
  // Counts ingress bytes handed on, to see what was stripped or dropped.
  always @(posedge clk) if (iv === 1'h1) in_cnt = in_cnt + 1;
  task check(input [63:0] seen, input [63:0] exp, input [79:0] what);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task test_done;
    begin
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
    end
  endtask
  task wreg(input [7:0] a, input [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'h1;
      @(posedge clk);
      wr <= 1'h0;
    end
  endtask
  // Read data stand only in the cycle after the strobe.
  task rreg(input [7:0] a, output [31:0] d);
    begin
      @(posedge clk);
      addr <= a;
      rd <= 1'h1;
      @(posedge clk);
      rd <= 1'h0;
      @(negedge clk);
      d = rdata;
    end
  endtask
  // Header as the host should see it; miss and flood force the target.
  function [63:0] hdr_exp(input [15:0] e);
    reg [1:0] f;
    begin
      f = ms ? `CTH_FOP_UC : (fl ? `CTH_FOP_MC : fop);
      hdr_exp = {e, f, (ms || fl) ? 12'h0 : tgt,
        (f == `CTH_FOP_EXC && tgt[3:0] == `CTH_EXC_TRAP) ? pp : source_port_group,
        knd, chip, slif, 3'h0, inst};
    end
  endfunction
  // Ready is looked at before the edge, so a byte is held until taken.
  task eg_frame(input integer n);
    begin
      clr <= 1'h1;
      @(posedge clk);
      clr <= 1'h0;
      for (k = 0; k < n; k = k + 1) begin
        ev <= 1'h1;
        ed <= pb + k[7:0];
        es <= (k == 0);
        ee <= (k == n - 1);
        @(negedge clk);
        while (erdy !== 1'h1) @(negedge clk);
        @(posedge clk);
      end
      ev <= 1'h0;
      for (j = 0; j < 300 && i_host.done_r !== 1'h1; j = j + 1)
        @(posedge clk);
    end
  endtask
  // The gap after the header lets the address replay finish first.
  task rx_frame(input integer nb);
    begin
      in_cnt = 0;
      nh = (hv[63:48] == et) ? 20 : 14;
      for (k = 0; k < nh + nb; k = k + 1) begin
        @(posedge clk);
        if (k == nh) begin
          rv <= 1'h0;
          repeat (14) begin
            rx_d <= ~rx_d;
            @(posedge clk);
          end
        end
        rv <= 1'h1;
        rs <= (k == 0);
        re <= (k == nh + nb - 1);
        rx_d <= (k < 12 || k >= nh) ? pb + k[7:0] : hv[8 * (19 - k) +: 8];
      end
      @(posedge clk);
      rv <= 1'h0;
      repeat (30) @(posedge clk);
    end
  endtask
  initial begin
    #400000;
    n_errors = n_errors + 1;
    test_done;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst_b <= 1'h1;
    rreg(`CTH_REG_ETYPE, rdv);
    check(rdv, {16'h0, `CTH_ETYPE_RST}, "etype_rst");
    ce <= 1'h0;
    wreg(`CTH_REG_CHIP, 32'h3);
    ce <= 1'h1;
    rreg(`CTH_REG_CHIP, rdv);
    check(rdv, {30'h0, `CTH_CHIP_RST}, "chip_rst");
    rreg(8'h40, rdv);
    check(rdv, 32'h0, "unmapped");
    rnd = $random(seed);
    et = rnd[15:0] | 16'h8000;
    tse = rnd[31:16];
    wreg(`CTH_REG_ETYPE, {16'h0, et});
    wreg(`CTH_REG_TS_ETYPE, {16'h0, tse});
    rreg(`CTH_REG_ETYPE, rdv);
    check(rdv, {16'h0, et}, "etype_rd");
    // Egress: port edit, lif edit with miss, flood, mirror, trap, none.
    for (i = 0; i < 6; i = i + 1) begin
      rnd = $random(seed);
      pb = rnd[31:24];
      stall <= i[0];
      pe <= (i != 1 && i != 5);
      le <= (i == 1);
      ms <= (i == 1);
      fl <= (i == 2);
      fop <= (i == 2) ? 2'h1 : (i > 2) ? 2'h2 : 2'h0;
      tgt <= {rnd[7:0], (i == 4) ? `CTH_EXC_TRAP : `CTH_EXC_MIRROR};
      slif <= rnd[19:8];
      inst <= {rnd[23:20], rnd[7:0]};
      rnd = $random(seed);
      {knd, chip, pp, source_port_group} <= rnd[10:0];
      ts <= {rnd, rnd[15:0] ^ 16'ha5c3};
      if (i == 4) wreg(`CTH_REG_CTRL, 32'h4);
      if (i == 5) wreg(`CTH_REG_CTRL, 32'h0);
      eg_frame(20 + i);
      hv = hdr_exp(et);
      tv = {tse, ts};
      nh = (i == 5) ? 0 : (i == 4) ? 16 : 8;
      check(i_host.n_got, 20 + i + nh, "tx_len");
      for (k = 0; k < 20 + i + nh; k = k + 1) begin
        if (k < 12) eb = pb + k[7:0];
        else if (k >= 12 + nh) eb = pb + k[7:0] - nh[7:0];
        else if (k < 20) eb = hv[8 * (19 - k) +: 8];
        else eb = tv[8 * (27 - k) +: 8];
        check(i_host.got[k], eb, "tx_byte");
      end
    end
    // Ingress: lif unicast, raw port, flood, mirror, trap.
    for (i = 0; i < 5; i = i + 1) begin
      rnd = $random(seed);
      hv = {et, rnd, 16'h0} | ($random(seed) & 32'hffff);
      hv[14:12] = 3'h0;
      hv[47:46] = (i == 2) ? 2'h1 : (i > 2) ? 2'h2 : 2'h0;
      if (i == 1 || i == 2) hv[45:34] = 12'h0;
      if (i > 2) hv[37:34] = (i == 3) ? `CTH_EXC_MIRROR : `CTH_EXC_TRAP;
      if (i == 0) hv[34] = 1'h1;
      pb = rnd[31:24];
      rx_frame(6 + i);
      check(itag, 1'h1, "in_tag");
      check(in_cnt, 18 + i, "in_len");
      check({i_fop, i_tgt}, hv[47:34], "in_fwd");
      check({ikind, i_chip, i_slif, i_inst}, {hv[29:15], hv[11:0]},
        "in_src");
      if (i == 0) check({iraw, i_spg}, {1'h0, hv[33:30]}, "in_uc");
      if (i == 1) check({iraw, i_pp}, {1'h1, hv[33:30]}, "in_raw");
      if (i == 2) check(ifl, 1'h1, "in_flood");
      if (i == 3) check(i_mg, hv[41:38], "in_mirror");
      if (i == 4) check({itrap, i_pp}, {1'h1, hv[33:30]}, "in_trap");
    end
    hv[63:48] = 16'h0800;
    rx_frame(6);
    check({itag, ilrn, in_cnt[7:0]}, {2'h1, 8'h14}, "in_plain");
    wreg(`CTH_REG_CTRL, 32'h1);
    rx_frame(6);
    check(in_cnt, 0, "drop_cnt");
    rreg(`CTH_REG_STATUS, rdv);
    check(rdv[0], 1'h1, "drop_flag");
    wreg(`CTH_REG_CTRL, 32'h9);
    rreg(`CTH_REG_STATUS, rdv);
    check(rdv[0], 1'h0, "drop_clr");
    hv[63:48] = et;
    rx_frame(4);
    check({itag, in_cnt[7:0]}, {1'h1, 8'h10}, "casc_tag");
    test_done;
  end
endmodule
